// File: core/qdac_consts.svh
// Constants of the quad converter register block: offsets, fields, resets.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// Behaviour
// - No-operation bit ignored, always reads zero
// - Per-channel scale bits 5..2, reset one
// - Command bits 1..0 discarded, read zero
// - Monitor one-hot bits 11..15 pick source
// - All monitor bits zero: output high-impedance
// - Monitor bits 10..0 discarded, read zero
// - Monitor register resets to zero
// - Data register feeds output latch on load, if written since the last load
// - Input data registers reset to zero
// - Bipolar codes are twos complement
// - Unipolar codes are straight binary
// - Zero-calibration register per channel, reset zero
// - Calibration nine bits, eighth step each
// - Calibration twos complement in both modes
// - Readback source bit picks input or latch
// - Sync update loads accessed latches, self-clears
`ifndef QDAC_CONSTS_SVH
`define QDAC_CONSTS_SVH

`define QDAC_ADDR_CMD       8'h00
`define QDAC_ADDR_MON       8'h04
`define QDAC_ADDR_DATA0     8'h10
`define QDAC_ADDR_ZERO0     8'h20
`define QDAC_ADDR_STRIDE    8'h04

`define QDAC_CMD_READBACK   15
`define QDAC_CMD_SYNC       14
`define QDAC_CMD_BIPOLAR    13
`define QDAC_CMD_NOP        6
`define QDAC_CMD_SCALE_LO   2
`define QDAC_CMD_SCALE_HI   5
`define QDAC_CMD_WMASK      16'hA03C
`define QDAC_MON_LO         11
`define QDAC_MON_WMASK      16'hF800
`define QDAC_ZERO_WMASK     16'h01FF

`define QDAC_SCALE_RESET    4'hF
`define QDAC_MON_RESET      16'h0000
`define QDAC_DATA_RESET     16'h0000
`define QDAC_ZERO_RESET     9'h000
`define QDAC_SYNC_CLR_CYC   1

`endif

// File: core/qdac_pkg.sv
// Types shared by the quad converter register block.
// Assumes the constants header is included by each user.
package qdac_pkg;
    typedef logic [15:0] qdac_word_type;
    typedef logic [8:0]  qdac_zero_type;
    typedef logic [4:0]  qdac_mon_type;
    // Corrected code with three fraction bits and headroom
    typedef logic signed [19:0] qdac_corr_type;
    typedef enum logic [1:0] {QDAC_IDLE, QDAC_ACK} qdac_bus_state_type;
endpackage

// File: core/qdac_chan_corr.sv
// One channel's zero correction of the latched code.
// Assumes code and calibration are stable register outputs.
`timescale 1ns/1ps
`include "qdac_consts.svh"
`default_nettype none
module qdac_chan_corr (
    // Clocking
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    // Inputs
    input  wire qdac_pkg::qdac_word_type code,
    input  wire qdac_pkg::qdac_zero_type zero_cal,
    input  wire logic                    bipolar,
    // Result
    output var  qdac_pkg::qdac_corr_type corrected
);
    import qdac_pkg::*;
    qdac_corr_type corr_reg;
    qdac_corr_type corr_next;
    qdac_corr_type code_ext;
    qdac_corr_type zero_ext;

    // Unipolar codes are lifted to signed by zero extension
    always_comb begin
        if (bipolar) begin
            // One sign bit of headroom: 1 + 16 + 3 fraction bits
            code_ext = {code[15], code, 3'b000};
        end else begin
            code_ext = {1'b0, code, 3'b000};
        end
        zero_ext = {{11{zero_cal[8]}}, zero_cal};
        corr_next = code_ext + zero_ext;
    end

    // Registered so the adder is off the output path
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            corr_reg <= 20'sh0_0000;
        end else begin
            corr_reg <= corr_next;
        end
    end
    assign corrected = corr_reg;
endmodule
`default_nettype wire

// File: core/qdac_regs.sv
// Register file of a quad converter: command, monitor, data, zero calibration.
// Assumes a classic Wishbone master on ref_clk; load pin arrives asynchronously.
`timescale 1ns/1ps
`include "qdac_consts.svh"
`default_nettype none
module qdac_regs (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    // Wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output var  logic [31:0]             wb_dat_o,
    output var  logic                    wb_ack_o,
    // Load pin, active low
    input  wire logic                    latch_load_pin_n,
    // Converter side
    output var  logic [3:0]              scale_x4,
    output var  qdac_pkg::qdac_mon_type  monitor_sel,
    output var  logic                    monitor_output_pin_oe_n,
    output var  logic                    bipolar_mode,
    output var  qdac_pkg::qdac_corr_type chan_code0,
    output var  qdac_pkg::qdac_corr_type chan_code1,
    output var  qdac_pkg::qdac_corr_type chan_code2,
    output var  qdac_pkg::qdac_corr_type chan_code3
);
    import qdac_pkg::*;

    // Command and monitor register state
    logic          readback_reg;
    logic          readback_next;
    logic          sync_reg;
    logic          sync_next;
    logic          bipolar_reg;
    logic          bipolar_next;
    logic [3:0]    scale_reg;
    logic [3:0]    scale_next;
    qdac_mon_type  mon_reg;
    qdac_mon_type  mon_next;
    logic          oe_n_reg;
    logic          oe_n_next;
    // Channel storage
    qdac_word_type data_reg    [4];
    qdac_word_type data_next   [4];
    qdac_word_type latch_reg   [4];
    qdac_word_type latch_next  [4];
    qdac_zero_type zero_reg    [4];
    qdac_zero_type zero_next   [4];
    logic [3:0]    accessed_reg;
    logic [3:0]    accessed_next;
    // Bus state
    qdac_bus_state_type bus_reg;
    qdac_bus_state_type bus_next;
    logic [31:0]   rdat_reg;
    logic [31:0]   rdat_next;
    // Load pin synchroniser and edge detect; corrector outputs
    logic          ld_meta_reg;
    logic          ld_sync_reg;
    logic          ld_prev_reg;
    qdac_corr_type corr [4];

    logic          wr_en;
    logic          rd_en;
    logic          load_pulse;
    logic [15:0]   wdat;
    qdac_word_type wmerged;

    // Only the low two byte lanes carry register data
    always_comb begin
        wdat[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
        wdat[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00;
        wr_en      = wb_cyc_i && wb_stb_i && wb_we_i && (bus_reg == QDAC_IDLE);
        rd_en      = wb_cyc_i && wb_stb_i && !wb_we_i && (bus_reg == QDAC_IDLE);
        wmerged    = wdat;
    end

    // Two flops before the pin is looked at
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ld_meta_reg <= 1'b1;
            ld_sync_reg <= 1'b1;
            ld_prev_reg <= 1'b1;
        end else begin
            ld_meta_reg <= latch_load_pin_n;
            ld_sync_reg <= ld_meta_reg;
            ld_prev_reg <= ld_sync_reg;
        end
    end

    // Falling pin edge, or the sync bit while the pin idles high
    assign load_pulse = (ld_prev_reg && !ld_sync_reg) || (sync_reg && ld_sync_reg);

    // Register next-state logic
    always_comb begin
        readback_next = readback_reg;
        sync_next     = 1'b0;
        bipolar_next  = bipolar_reg;
        scale_next    = scale_reg;
        mon_next      = mon_reg;
        accessed_next = load_pulse ? 4'h0 : accessed_reg;
        for (int i = 0; i < 4; i++) begin
            data_next[i]  = data_reg[i];
            zero_next[i]  = zero_reg[i];
            // Only channels written since the last load are reloaded
            latch_next[i] = (load_pulse && accessed_reg[i]) ? data_reg[i] : latch_reg[i];
        end
        if (wr_en) begin
            // NO_OPERATION_BIT, reserved bits dropped: only the named fields are taken
            if (wb_adr_i == `QDAC_ADDR_CMD) begin
                readback_next = wmerged[`QDAC_CMD_READBACK];
                sync_next     = wmerged[`QDAC_CMD_SYNC] && ld_sync_reg;
                bipolar_next  = wmerged[`QDAC_CMD_BIPOLAR];
                scale_next    = wmerged[`QDAC_CMD_SCALE_HI:`QDAC_CMD_SCALE_LO];
            end
            if (wb_adr_i == `QDAC_ADDR_MON) begin
                // Host keeps this one-hot; stored as written
                mon_next = wmerged[15:`QDAC_MON_LO];
            end
            for (int i = 0; i < 4; i++) begin
                if (wb_adr_i == 8'(`QDAC_ADDR_DATA0 + `QDAC_ADDR_STRIDE * i)) begin
                    data_next[i]     = wmerged;
                    accessed_next[i] = 1'b1; // Set wins over load clear
                end
                if (wb_adr_i == 8'(`QDAC_ADDR_ZERO0 + `QDAC_ADDR_STRIDE * i)) begin
                    zero_next[i] = wmerged[8:0];
                end
            end
        end
        oe_n_next = (mon_next == 5'h00);
    end

    // Read data and acknowledge
    always_comb begin
        bus_next  = (bus_reg == QDAC_IDLE && wb_cyc_i && wb_stb_i) ? QDAC_ACK : QDAC_IDLE;
        rdat_next = 32'h0000_0000; // Unmapped reads return zero
        if (rd_en) begin
            if (wb_adr_i == `QDAC_ADDR_CMD) begin
                // NO_OPERATION_BIT and low bits read zero
                rdat_next = {16'h0000, readback_reg, sync_reg, bipolar_reg, 7'h00,
                             scale_reg, 2'b00};
            end
            if (wb_adr_i == `QDAC_ADDR_MON) begin
                rdat_next = {16'h0000, mon_reg, 11'h000};
            end
            for (int i = 0; i < 4; i++) begin
                if (wb_adr_i == 8'(`QDAC_ADDR_DATA0 + `QDAC_ADDR_STRIDE * i)) begin
                    rdat_next = {16'h0000, readback_reg ? latch_reg[i] : data_reg[i]};
                end
                if (wb_adr_i == 8'(`QDAC_ADDR_ZERO0 + `QDAC_ADDR_STRIDE * i)) begin
                    rdat_next = {23'h00_0000, zero_reg[i]};
                end
            end
        end
    end

    // State registers; all clear to documented defaults
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            readback_reg <= 1'b0;
            sync_reg     <= 1'b0;
            bipolar_reg  <= 1'b0;
            scale_reg    <= `QDAC_SCALE_RESET;
            mon_reg      <= 5'(`QDAC_MON_RESET >> `QDAC_MON_LO);
            oe_n_reg     <= 1'b1;
            accessed_reg <= 4'h0;
            bus_reg      <= QDAC_IDLE;
            rdat_reg     <= 32'h0000_0000;
            for (int i = 0; i < 4; i++) begin
                data_reg[i]  <= `QDAC_DATA_RESET;
                latch_reg[i] <= `QDAC_DATA_RESET;
                zero_reg[i]  <= `QDAC_ZERO_RESET;
            end
        end else begin
            readback_reg <= readback_next;
            sync_reg     <= sync_next;
            bipolar_reg  <= bipolar_next;
            scale_reg    <= scale_next;
            mon_reg      <= mon_next;
            oe_n_reg     <= oe_n_next;
            accessed_reg <= accessed_next;
            bus_reg      <= bus_next;
            rdat_reg     <= rdat_next;
            for (int i = 0; i < 4; i++) begin
                data_reg[i]  <= data_next[i];
                latch_reg[i] <= latch_next[i];
                zero_reg[i]  <= zero_next[i];
            end
        end
    end

    // One corrector per channel
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_corr
            qdac_chan_corr u_corr (
                .ref_clk   (ref_clk),
                .nrst      (nrst),
                .code      (latch_reg[g]),
                .zero_cal  (zero_reg[g]),
                .bipolar   (bipolar_reg),
                .corrected (corr[g])
            );
        end
    endgenerate

    // Outputs straight from flops
    assign wb_ack_o                = (bus_reg == QDAC_ACK);
    assign wb_dat_o                = rdat_reg;
    assign scale_x4                = scale_reg;
    assign monitor_sel             = mon_reg;
    assign monitor_output_pin_oe_n = oe_n_reg;
    assign bipolar_mode            = bipolar_reg;
    assign chan_code0              = corr[0];
    assign chan_code1              = corr[1];
    assign chan_code2              = corr[2];
    assign chan_code3              = corr[3];
endmodule
`default_nettype wire

// File: testbench/qdac_regs_properties.sv
// Checker of the register block, bound to its ports.
// Assumes one clock and a master that idles a cycle after each ack.
`timescale 1ns/1ps
`default_nettype none
module qdac_regs_properties (
    // Clock and reset
    input wire logic                    ref_clk,
    input wire logic                    nrst,
    // Bus
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [7:0]              wb_adr_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    // Converter side
    input wire logic [3:0]              scale_x4,
    input wire qdac_pkg::qdac_mon_type  monitor_sel,
    input wire logic                    monitor_output_pin_oe_n,
    input wire qdac_pkg::qdac_corr_type chan_code0
);
    import qdac_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic take;
    // Request first seen by an idle slave
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    ack_pulse_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack missing or longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    oe_tie_a: assert property (monitor_output_pin_oe_n == (monitor_sel == 5'h00))
        else $error("monitor enable disagrees with selection");
    mon_write_a: assert property (take && wb_we_i && wb_adr_i == 8'h04
        |=> monitor_sel == $past(wb_dat_i[15:11])) else $error("monitor write lost");
    cmd_write_a: assert property (take && wb_we_i && wb_adr_i == 8'h00
        |=> scale_x4 == $past(wb_dat_i[5:2])) else $error("scale write lost");
    cmd_read_a: assert property (take && !wb_we_i && wb_adr_i == 8'h00
        |=> wb_dat_o[6] == 1'b0 && wb_dat_o[1:0] == 2'b00 && wb_dat_o[5:2] == $past(scale_x4))
        else $error("command read wrong");
    mon_read_a: assert property (take && !wb_we_i && wb_adr_i == 8'h04
        |=> wb_dat_o[15:0] == {$past(monitor_sel), 11'h000}) else $error("monitor read wrong");
    // Data register, latch and corrector add three stages, so look past all three of them
    data_hold_a: assert property (take && wb_we_i && wb_adr_i == 8'h10
        |-> ##3 chan_code0 == $past(chan_code0, 3)) else $error("code moved without load");
    // Flops start unknown; reset values show one edge after reset is seen
    reset_vals_a: assert property (disable iff (1'b0) !nrst
        |=> scale_x4 == 4'hf && monitor_sel == 5'h00 && chan_code0 == 20'h0_0000)
        else $error("reset value wrong");
endmodule
`default_nettype wire

// File: testbench/qdac_host.sv
// Host model: a classic Wishbone master reaching the register block.
// Assumes access is called right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module qdac_host (
    // Clock
    input  wire logic        ref_clk,
    // Bus towards the slave
    output var  logic        cyc,
    output var  logic        stb,
    output var  logic        we,
    output var  logic [7:0]  adr,
    output var  logic [3:0]  sel,
    output var  logic [31:0] dat_w,
    input  wire logic [31:0] dat_r,
    input  wire logic        ack
);
    // Idle bus; only the two low lanes carry a register
    initial {cyc, stb, we, adr, sel, dat_w} = {3'b000, 8'h00, 4'h3, 32'h0000_0000};
    // Hold the request until ack is sampled, then release it for a cycle
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
                          output logic [31:0] q);
        {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'h3, 16'h0000, d};
        @(posedge ref_clk);
        while (ack !== 1'b1) begin
            @(posedge ref_clk);
        end
        q = dat_r;
        {cyc, stb} <= 2'b00;
        dat_w <= ~dat_w; // Released data shows no stale value
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// File: testbench/qdac_regs_tb.sv
// Self-checking bench of the quad converter register block.
// Assumes the host model drives the bus; the checker is bound at the foot.
`timescale 1ns/1ps
`default_nettype none
`define chk(act, exp) begin \
    checked++; \
    if ((act) !== (exp)) begin \
        error_cnt++; \
        $display("wrong value at %0t: got %h, want %h", $time, act, exp); \
    end \
end
module qdac_regs_tb;
    import qdac_pkg::*;
    // Clock, reset, load pin, bus and converter-side nets
    logic          ref_clk = 1'b0;
    logic          nrst = 1'b0;
    logic          load_n = 1'b1;
    logic          cyc, stb, we, ack, oe_n, bip;
    logic [7:0]    adr;
    logic [3:0]    sel, scale;
    logic [31:0]   dw, dr, q;
    qdac_mon_type  mon;
    qdac_corr_type code [4];
    int            error_cnt = 0;
    int            checked = 0;
    int            cycles = 0;
    qdac_host i_qdac_host (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat_w(dw), .dat_r(dr), .ack(ack));
    qdac_regs i_qdac_regs (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .latch_load_pin_n(load_n), .scale_x4(scale), .monitor_sel(mon),
        .monitor_output_pin_oe_n(oe_n), .bipolar_mode(bip), .chan_code0(code[0]),
        .chan_code1(code[1]), .chan_code2(code[2]), .chan_code3(code[3]));
    // Free-running 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // Cut a hang short, far beyond the few hundred cycles needed
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("mismatches %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Bus helpers
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_qdac_host.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        i_qdac_host.access(1'b0, a, 16'h0000, q);
        `chk(q, e)
    endtask
    // Latched code with three fraction bits plus sign-extended calibration
    function automatic qdac_corr_type corr(input logic [15:0] c, input logic [8:0] z,
                                           input logic b);
        qdac_corr_type v;
        v = b ? {{4{c[15]}}, c} : {4'h0, c};
        return (v <<< 3) + {{11{z[8]}}, z};
    endfunction
    // Pin low long enough for its synchroniser and the latch
    task automatic pulse_load;
        load_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        load_n <= 1'b1;
        @(posedge ref_clk);
    endtask
    // Values straight after reset
    task automatic t_reset;
        rd(8'h00, 32'h0000_003c);
        rd(8'h04, 32'h0000_0000);
        for (int n = 0; n < 4; n++) begin
            rd(8'h10 + 8'(4 * n), 32'h0000_0000);
            rd(8'h20 + 8'(4 * n), 32'h0000_0000);
        end
        `chk(oe_n, 1'b1)
    endtask
    // Reserved and no-operation bits, then one scale bit at a time
    task automatic t_cmd;
        wr(8'h00, 16'hffff);
        rd(8'h00, 32'h0000_a03c);
        for (int n = 0; n < 4; n++) begin
            wr(8'h00, 16'(16'h0004 << n));
            `chk(scale, 4'(4'h1 << n))
        end
    endtask
    // Every monitor source, with the reserved bits written high
    task automatic t_monitor;
        for (int i = 0; i < 5; i++) begin
            wr(8'h04, 16'(16'h07ff | (16'h0800 << i))); // One source only
            rd(8'h04, 32'(16'h0800 << i));
            `chk(mon, 5'(5'h01 << i))
            `chk(oe_n, 1'b0)
        end
        wr(8'h04, 16'h0000);
        `chk(oe_n, 1'b1)
        rd(8'h40, 32'h0000_0000);
    endtask
    // Boundary codes and calibrations through the load pin; bipolar round first
    task automatic t_codes(input logic b);
        logic [15:0] c [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0000};
        logic [8:0]  z [4] = '{9'h0ff, 9'h100, 9'h1ff, 9'h001};
        wr(8'h00, {2'b10, b, 13'h0000});
        `chk(bip, b)
        for (int n = 0; n < 4; n++) begin
            wr(8'h20 + 8'(4 * n), 16'hfe00 | 16'(z[n]));
            rd(8'h20 + 8'(4 * n), 32'(z[n]));
            wr(8'h10 + 8'(4 * n), c[n]);
            rd(8'h10 + 8'(4 * n), b ? 32'h0000_0000 : 32'(c[n]));
        end
        pulse_load();
        for (int n = 0; n < 4; n++) begin
            `chk(code[n], corr(c[n], z[n], b))
            rd(8'h10 + 8'(4 * n), 32'(c[n]));
        end
    endtask
    // Update bit loads once, and is ignored while the pin is low
    task automatic t_sync;
        wr(8'h14, 16'h0042);
        wr(8'h00, 16'h4000);
        repeat (6) @(posedge ref_clk);
        `chk(code[1], corr(16'h0042, 9'h100, 1'b0))
        load_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        wr(8'h14, 16'h0043);
        wr(8'h00, 16'h4000);
        repeat (6) @(posedge ref_clk);
        `chk(code[1], corr(16'h0042, 9'h100, 1'b0))
        rd(8'h14, 32'h0000_0043);
        load_n <= 1'b1;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_cmd();
        t_monitor();
        t_codes(1'b1);
        t_codes(1'b0);
        t_sync();
        tally_and_finish();
    end
endmodule
bind qdac_regs qdac_regs_properties i_qdac_regs_properties (.ref_clk, .nrst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .scale_x4,
    .monitor_sel, .monitor_output_pin_oe_n, .chan_code0);
`default_nettype wire
